// *** hw/rifd_decoder.v ***
// Instruction field decoder with four-phase timing and one-cycle flush
//
// How it works
// - Each 14-bit word splits into an operation code and operand fields.
// - Every word lands in exactly one of byte, bit, or literal/control class.
// - A byte operation with destination select 0 writes the working register, except in the misc group (code 0).
// - A byte operation with destination select 1 writes the named file register.
// - The file address is a seven-bit direct address covering 0x00 to 0x7F.
// - Bit operations pick one bit of an 8-bit file register named by the address.
// - The literal is eight bits for literal operations and eleven for jump addresses.
// - Don't-care bits never change the decoded operation.
// - Skips taken and program counter changes take a second cycle that does nothing.
// - One instruction cycle is four oscillator periods, decode and execute keyed to it.
// - Byte class is 00, four-bit code, destination select, seven-bit address.
// - Bit class is 01, two-bit code, three-bit bit select, seven-bit address.
// - Literal class is 11 with the eight-bit literal in the low byte.
`timescale 1ns/1ps
`default_nettype none
`include "rifd_regs.vh"
module rifd_decoder (
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire [13:0] instr_i,
  input  wire        skip_true_i,
  output wire [1:0]  phase_o,
  output wire        fetch_o,
  output reg  [1:0]  op_class_o,
  output reg  [3:0]  byte_op_o,
  output reg  [1:0]  bit_op_o,
  output reg  [3:0]  lit_op_o,
  output reg         dest_file_o,
  output reg         write_w_o,
  output reg         write_file_o,
  output reg  [6:0]  file_addr_o,
  output reg  [2:0]  bit_sel_o,
  output reg  [7:0]  bit_mask_o,
  output reg  [7:0]  literal_o,
  output reg  [10:0] jump_addr_o,
  output reg         pc_change_o,
  output reg         skip_test_o,
  output reg         exec_valid_o,
  output reg         flush_o
);
  wire       cycle_start;
  wire       cycle_end;
  wire [1:0] word_cls;
  wire [3:0] byte_code;
  wire [1:0] bit_code;
  wire [1:0] lit_code;
  wire       dest_sel;
  wire [2:0] bit_pick;
  reg  [1:0] cls_next;
  reg        pcchg_next;
  reg        skip_next;
  reg        wrw_next;
  reg        wrf_next;
  reg        flush_reg;
  reg        flush_next;

  // Class from the two leading bits; a plain 2-bit case covers all words once
  function [1:0] rifd_class;
    input [13:0] w;
    begin
      rifd_class = w[`RIFD_CLS_MSB:`RIFD_CLS_LSB];
    end
  endfunction

  // One-hot bit mask, used for the datapath bit operation
  function [7:0] rifd_mask;
    input [2:0] b;
    begin
      rifd_mask = 8'h01 << b;
    end
  endfunction

  // Byte codes that count a file register and skip on zero
  function rifd_byte_skips;
    input [3:0] code;
    begin
      rifd_byte_skips = (code == `RIFD_OP_DEC_SKIP) || (code == `RIFD_OP_INC_SKIP);
    end
  endfunction

  // Bit codes that test a bit and skip: the two upper codes of the group
  function rifd_bit_skips;
    input [1:0] code;
    begin
      rifd_bit_skips = (code == `RIFD_BOP_TEST_CLR) || (code == `RIFD_BOP_TEST_SET);
    end
  endfunction

  // Whole-word match for the two returns; other misc words leave the PC alone
  function rifd_misc_returns;
    input [13:0] w;
    begin
      rifd_misc_returns = (w == `RIFD_W_RET_SUB) || (w == `RIFD_W_RET_INT);
    end
  endfunction

  // Named slices of the incoming word, shared by the decode below
  assign word_cls  = rifd_class(instr_i);
  assign byte_code = instr_i[`RIFD_BYTE_OP_MSB:`RIFD_BYTE_OP_LSB];
  assign bit_code  = instr_i[`RIFD_BIT_OP_MSB:`RIFD_BIT_OP_LSB];
  assign lit_code  = instr_i[`RIFD_LIT_OP_MSB:`RIFD_LIT_SEL_LSB];
  assign dest_sel  = instr_i[`RIFD_DEST_BIT];
  assign bit_pick  = instr_i[`RIFD_BSEL_MSB:`RIFD_BSEL_LSB];

  rifd_phase_gen u_phase (
    .clk_i         (clk_i),
    .arst_n_i      (arst_n_i),
    .phase_o       (phase_o),
    .cycle_start_o (cycle_start),
    .cycle_end_o   (cycle_end)
  );

  // Fetch strobe at the last phase so the next word is latched at cycle start
  assign fetch_o = cycle_end;

  // Combinational class and effect decode of the incoming word
  always @* begin
    cls_next   = word_cls;
    pcchg_next = 1'b0;
    skip_next  = 1'b0;
    wrw_next   = 1'b0;
    wrf_next   = 1'b0;
    case (cls_next)
      `RIFD_CLS_BYTE: begin
        if (byte_code == `RIFD_OP_MISC) begin
          // Move to file when d set; else only control words, none write data
          wrf_next   = dest_sel;
          pcchg_next = rifd_misc_returns(instr_i);
        end else begin
          wrw_next  = ~dest_sel;
          wrf_next  = dest_sel;
          skip_next = rifd_byte_skips(byte_code);
        end
      end
      `RIFD_CLS_BIT: begin
        skip_next = rifd_bit_skips(bit_code);
        // Clear and set write the file back; the tests only read it
        wrf_next  = ~bit_code[1];
      end
      `RIFD_CLS_JUMP: begin
        // Call and go-to always load the PC, so they always take two cycles
        pcchg_next = 1'b1;
      end
      `RIFD_CLS_LIT: begin
        // Every literal operation writes W, the return with literal too
        wrw_next   = 1'b1;
        pcchg_next = (lit_code == `RIFD_LOP_RET_LIT);
      end
      default: begin
        wrw_next = 1'b0;
      end
    endcase
  end

  // Flush request: a branch, or a skip whose test the datapath reports true
  // Held outside phase 3 so the decision survives to the next phase-0 edge
  // A test reported false costs nothing: the next word runs at once
  always @* begin
    flush_next = flush_reg;
    if (cycle_end) begin
      flush_next = exec_valid_o && (pc_change_o || (skip_test_o && skip_true_i));
    end
  end

  // Fields latched at cycle start and held stable for all four phases
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_class_o   <= 2'h0;
      byte_op_o    <= 4'h0;
      bit_op_o     <= 2'h0;
      lit_op_o     <= 4'h0;
      dest_file_o  <= 1'b0;
      write_w_o    <= 1'b0;
      write_file_o <= 1'b0;
      file_addr_o  <= 7'h00;
      bit_sel_o    <= 3'h0;
      bit_mask_o   <= 8'h00;
      literal_o    <= 8'h00;
      jump_addr_o  <= 11'h000;
      pc_change_o  <= 1'b0;
      skip_test_o  <= 1'b0;
      exec_valid_o <= 1'b0;
      // Effects low and no flush pending, so the first word runs
      flush_reg    <= 1'b0;
      flush_o      <= 1'b0;
    end else begin
      // Flush state moves every edge but only changes at phase 3
      flush_reg <= flush_next;
      if (cycle_start) begin
        // Fields come straight from the word; x bits are never consulted
        op_class_o   <= cls_next;
        byte_op_o    <= instr_i[`RIFD_BYTE_OP_MSB:`RIFD_BYTE_OP_LSB];
        bit_op_o     <= instr_i[`RIFD_BIT_OP_MSB:`RIFD_BIT_OP_LSB];
        lit_op_o     <= instr_i[`RIFD_LIT_OP_MSB:`RIFD_LIT_OP_LSB];
        dest_file_o  <= instr_i[`RIFD_DEST_BIT];
        file_addr_o  <= instr_i[`RIFD_FILE_MSB:`RIFD_FILE_LSB];
        bit_sel_o    <= bit_pick;
        bit_mask_o   <= rifd_mask(bit_pick);
        literal_o    <= instr_i[`RIFD_LIT_MSB:`RIFD_LIT_LSB];
        jump_addr_o  <= instr_i[`RIFD_ADDR_MSB:`RIFD_ADDR_LSB];
        // Gate every effect of the word fetched at phase 3 just before the flush cycle
        // Its fields still show, which keeps the datapath inputs defined
        flush_o      <= flush_reg;
        write_w_o    <= wrw_next & ~flush_reg;
        write_file_o <= wrf_next & ~flush_reg;
        pc_change_o  <= pcchg_next & ~flush_reg;
        skip_test_o  <= skip_next & ~flush_reg;
        exec_valid_o <= ~flush_reg;
      end
    end
  end
endmodule // rifd_decoder
`default_nettype wire

// *** hw/rifd_phase_gen.v ***
// Four-phase instruction cycle generator
`timescale 1ns/1ps
`default_nettype none
`include "rifd_regs.vh"
module rifd_phase_gen (
  input  wire       clk_i,
  input  wire       arst_n_i,
  output reg  [1:0] phase_o,
  output wire       cycle_start_o,
  output wire       cycle_end_o
);
  // Free-running phase count, one step per oscillator period
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_o <= 2'h0;
    end else begin
      phase_o <= phase_o + 2'h1;
    end
  end

  assign cycle_start_o = (phase_o == `RIFD_PHASE_FIRST);
  assign cycle_end_o   = (phase_o == `RIFD_PHASE_LAST); // Wraps after four periods
endmodule // rifd_phase_gen
`default_nettype wire

// *** hw/rifd_regs.vh ***
// Field positions, class codes, operation codes and timing counts of the instruction decoder
`ifndef RIFD_REGS_VH
`define RIFD_REGS_VH
`define RIFD_WORD_W        14
`define RIFD_CLS_MSB       13
`define RIFD_CLS_LSB       12
`define RIFD_CLS_BYTE      2'h0
`define RIFD_CLS_BIT       2'h1
`define RIFD_CLS_JUMP      2'h2
`define RIFD_CLS_LIT       2'h3
`define RIFD_BYTE_OP_MSB   11
`define RIFD_BYTE_OP_LSB   8
`define RIFD_DEST_BIT      7
`define RIFD_FILE_MSB      6
`define RIFD_FILE_LSB      0
`define RIFD_BIT_OP_MSB    11
`define RIFD_BIT_OP_LSB    10
`define RIFD_BSEL_MSB      9
`define RIFD_BSEL_LSB      7
`define RIFD_LIT_MSB       7
`define RIFD_LIT_LSB       0
`define RIFD_ADDR_MSB      10
`define RIFD_ADDR_LSB      0
`define RIFD_JUMP_SEL_BIT  11
`define RIFD_LIT_OP_MSB    11
`define RIFD_LIT_OP_LSB    8
`define RIFD_LIT_SEL_LSB   10
// Byte-oriented codes: the two that count and skip on zero, and the misc group
`define RIFD_OP_DEC_SKIP   4'hb
`define RIFD_OP_INC_SKIP   4'hf
`define RIFD_OP_MISC       4'h0
// Bit-oriented test codes
`define RIFD_BOP_TEST_CLR  2'h2
`define RIFD_BOP_TEST_SET  2'h3
// Control words inside the misc group
`define RIFD_W_RET_SUB     14'h0008
`define RIFD_W_RET_INT     14'h0009
`define RIFD_W_IDLE        14'h0000
// Literal group: bits 11:10 equal 01 is the return-with-literal
`define RIFD_LOP_RET_LIT   2'h1
// Oscillator periods per instruction cycle
`define RIFD_PHASES        4
`define RIFD_PHASE_W       2
`define RIFD_PHASE_FIRST   2'h0
`define RIFD_PHASE_LAST    2'h3
`endif

// *** verification/rifd_checker.sv ***
// Port assertions for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module rifd_checker (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic [13:0] instr_i,
  input wire logic        skip_true_i,
  input wire logic [1:0]  phase_o,
  input wire logic        fetch_o,
  input wire logic [6:0]  file_addr_o,
  input wire logic [2:0]  bit_sel_o,
  input wire logic [7:0]  bit_mask_o,
  input wire logic        write_w_o,
  input wire logic        write_file_o,
  input wire logic        pc_change_o,
  input wire logic        skip_test_o,
  input wire logic        exec_valid_o,
  input wire logic        flush_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [13:0] last_reg;
  // Word seen at the previous edge, the one a phase-0 edge latches
  always @(posedge clk_i) last_reg <= instr_i;
  // Branch or true test at the deciding edge
  sequence taken_s;
    phase_o == 2'h3 && exec_valid_o && (pc_change_o || (skip_test_o && skip_true_i));
  endsequence
  sequence quad_s;
    phase_o == 2'h1 ##1 phase_o == 2'h2 ##1 phase_o == 2'h3 ##1 phase_o == 2'h0;
  endsequence
  phase_order_a: assert property (phase_o == 2'h0 |=> quad_s)
    else $error("phase order broken");
  fetch_phase_a: assert property (fetch_o == (phase_o == 2'h3))
    else $error("fetch not in last phase");
  addr_latch_a: assert property (phase_o == 2'h1 |-> file_addr_o == last_reg[6:0])
    else $error("file address not from word");
  mask_onehot_a: assert property (phase_o == 2'h2 |-> bit_mask_o == 8'h01 << bit_sel_o)
    else $error("bit mask wrong");
  flush_taken_a: assert property (taken_s |-> ##2 flush_o && !exec_valid_o)
    else $error("second cycle not flushed");
  flush_none_a: assert property (phase_o == 2'h3 && !exec_valid_o |-> ##2 !flush_o)
    else $error("flush after flushed word");
  flush_quiet_a: assert property (
    flush_o |-> !(write_w_o || write_file_o || pc_change_o || skip_test_o))
    else $error("side effect in flush");
  fields_stand_a: assert property (
    phase_o != 2'h0 |=> $stable(file_addr_o) && $stable(flush_o))
    else $error("outputs moved mid cycle");
endmodule // rifd_checker
bind rifd_decoder rifd_checker i_rifd_checker (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .instr_i(instr_i), .skip_true_i(skip_true_i), .phase_o(phase_o), .fetch_o(fetch_o),
  .file_addr_o(file_addr_o), .bit_sel_o(bit_sel_o), .bit_mask_o(bit_mask_o),
  .write_w_o(write_w_o), .write_file_o(write_file_o), .pc_change_o(pc_change_o),
  .skip_test_o(skip_test_o), .exec_valid_o(exec_valid_o), .flush_o(flush_o));
`default_nettype wire

// *** verification/rifd_fetch_model.sv ***
// Program fetch and skip-result model beside the decoder
`timescale 1ns/1ps
`default_nettype none
module rifd_fetch_model (
  input  wire logic        clk_i,
  input  wire logic        fetch_i,
  input  wire logic [13:0] word_i,
  input  wire logic        skip_i,
  output var  logic [13:0] instr_o,
  output var  logic        skip_true_o
);
  initial instr_o = 14'h0000;
  initial skip_true_o = 1'b0;
  // Only on the fetch edge, so word and result stand a whole cycle
  always @(posedge clk_i) begin
    if (fetch_i) begin
      instr_o <= word_i;
      skip_true_o <= skip_i;
    end
  end
endmodule // rifd_fetch_model
`default_nettype wire

// *** verification/tb_risc_instruction_field_decoder.sv ***
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module tb_risc_instruction_field_decoder;
  logic        clk_i, arst_n_i, skip_r, cur_sk, cur_fl, skip_true_i, fetch_o;
  logic        dest_file_o, write_w_o, write_file_o, pc_change_o, skip_test_o;
  logic        exec_valid_o, flush_o;
  logic [1:0]  phase_o, op_class_o, bit_op_o;
  logic [3:0]  byte_op_o, lit_op_o;
  logic [2:0]  bit_sel_o;
  logic [6:0]  file_addr_o;
  logic [7:0]  bit_mask_o, literal_o;
  logic [10:0] jump_addr_o;
  logic [13:0] word_r, cur, instr_i, e;
  logic [31:0] lf;
  int          mismatches, cmp_count, cycles, i;
  logic [13:0] corner [0:9] = '{14'h0bff, 14'h0200, 14'h2fff, 14'h0880, 14'h0008,
                                14'h0009, 14'h1f80, 14'h00ff, 14'h3455, 14'h0200};
  rifd_decoder i_rifd_decoder (.clk_i(clk_i), .arst_n_i(arst_n_i), .instr_i(instr_i),
    .skip_true_i(skip_true_i), .phase_o(phase_o), .fetch_o(fetch_o), .op_class_o(op_class_o),
    .byte_op_o(byte_op_o), .bit_op_o(bit_op_o), .lit_op_o(lit_op_o), .dest_file_o(dest_file_o),
    .write_w_o(write_w_o), .write_file_o(write_file_o), .file_addr_o(file_addr_o),
    .bit_sel_o(bit_sel_o), .bit_mask_o(bit_mask_o), .literal_o(literal_o),
    .jump_addr_o(jump_addr_o), .pc_change_o(pc_change_o), .skip_test_o(skip_test_o),
    .exec_valid_o(exec_valid_o), .flush_o(flush_o));
  rifd_fetch_model i_rifd_fetch_model (.clk_i(clk_i), .fetch_i(fetch_o), .word_i(word_r),
    .skip_i(skip_r), .instr_o(instr_i), .skip_true_o(skip_true_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Flags: write W, write file, pc change, skip test, executes, flush, bit mask
  function automatic logic [13:0] exp_flags(input logic [13:0] w, input logic fl);
    logic pc, sk, ww, wf;
    pc = w[13:12] == 2'h2 || w == 14'h0008 || w == 14'h0009 || w[13:10] == 4'hd;
    sk = (w[13:12] == 2'h0 && w[11] && w[9:8] == 2'h3) || (w[13:12] == 2'h1 && w[11]);
    ww = w[13:12] == 2'h3 || (w[13:12] == 2'h0 && !w[7] && w[11:8] != 4'h0);
    wf = (w[13:12] == 2'h0 && w[7]) || (w[13:12] == 2'h1 && !w[11]);
    exp_flags = {!fl && ww, !fl && wf, !fl && pc, !fl && sk, !fl, fl, 8'h01 << w[9:7]};
  endfunction
  task automatic chk_fields(input logic [41:0] got, input logic [41:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t fields got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flags(input logic [13:0] got, input logic [13:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t flags got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Hang guard, far above the 90 words of four clocks each
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      wrap_up;
    end
  end
  initial begin
    {arst_n_i, skip_r, cur_sk, cur_fl} = 4'h0;
    {word_r, cur} = 28'h000_0000;
    lf = 32'h0001_020a;
    {mismatches, cmp_count, cycles} = 0;
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    // Corner words first, each with a true test, then random words and results
    for (i = 0; i < 90; i++) begin
      @(negedge clk_i);
      while (phase_o !== 2'h2) @(negedge clk_i);
      chk_fields({op_class_o, byte_op_o, bit_op_o, lit_op_o, file_addr_o, bit_sel_o, literal_o,
           jump_addr_o, dest_file_o}, {cur[13:12], cur[11:8], cur[11:10], cur[11:8],
           cur[6:0], cur[9:7], cur[7:0], cur[10:0], cur[7]});
      e = exp_flags(cur, cur_fl);
      chk_flags({write_w_o, write_file_o, pc_change_o, skip_test_o, exec_valid_o,
           flush_o, bit_mask_o}, e);
      lf = lfsr(lf);
      cur_fl = e[11] || (e[10] && cur_sk);
      cur = (i < 10) ? corner[i] : lf[13:0];
      cur_sk = (i < 10) ? 1'b1 : lf[20];
      // Next word and test result launched on the edge before the fetch edge
      @(posedge clk_i);
      word_r <= cur;
      skip_r <= cur_sk;
    end
    wrap_up;
  end
endmodule // tb_risc_instruction_field_decoder
`default_nettype wire
